// *** core/ssfg_pkg.sv ***
package ssfg_pkg;
  localparam int unsigned MAP_W = 64;
  localparam int unsigned COMP_LEGACY = 0;
  localparam int unsigned COMP_SIMD = 1;
  localparam int unsigned COMP_WIDE = 2;
  localparam int unsigned COMP_NUM = 3;
  localparam int unsigned SPECIAL_BIT = 63;
  localparam int unsigned L1_CLMUL_BIT = 1;
  localparam int unsigned L1_ROUND_BIT = 25;
  localparam int unsigned L1_BASIC_BIT = 26;
  localparam int unsigned L1_OSEN_BIT = 27;
  localparam int unsigned CR4_OSEN_BIT = 18;
  localparam int unsigned S1_OPT_BIT = 0;
  localparam int unsigned S1_COMPACT_BIT = 1;
  localparam int unsigned S1_READ1_BIT = 2;
  localparam int unsigned S1_SUPV_BIT = 3;
  localparam logic [31:0] LEAF_BASIC = 32'h0000_0001;
  localparam logic [31:0] LEAF_STATE = 32'h0000_000D;
  localparam logic [31:0] SUPV_MASK_INDEX = 32'h0000_0DA0;
  localparam logic [31:0] SEL_ENABLE = 32'h0000_0000;
  localparam logic [31:0] SEL_INIT = 32'h0000_0001;
  localparam logic [63:0] ENABLE_RESET = 64'h0000_0000_0000_0001;
  localparam logic [63:0] SUPV_RESET = 64'h0000_0000_0000_0000;
  localparam logic OSEN_RESET = 1'b0;
  localparam logic HAS_ROUND = 1'b1;
  localparam logic HAS_CLMUL = 1'b1;
  localparam logic HAS_BASIC = 1'b1;
  localparam logic HAS_OPT = 1'b1;
  localparam logic HAS_COMPACT = 1'b1;
  localparam logic HAS_READ1 = 1'b1;
  localparam logic HAS_SUPV = 1'b1;
  localparam logic [63:0] FULL_MAP = 64'h0000_0000_0000_0007;
  localparam logic [63:0] SUPV_MAP = 64'h0000_0000_0000_0000;
  localparam logic [31:0] LEGACY_BYTES = 32'h0000_0240;
  localparam logic [31:0] WIDE_BYTES = 32'h0000_0100;
  localparam logic [31:0] WIDE_OFFSET = 32'h0000_0240;

  typedef enum logic [3:0] {
    OP_ENABLE_READ = 4'h0,
    OP_ENABLE_WRITE = 4'h1,
    OP_STD_SAVE = 4'h2,
    OP_OPT_SAVE = 4'h3,
    OP_COMPACT_SAVE = 4'h4,
    OP_SUPV_SAVE = 4'h5,
    OP_STD_RESTORE = 4'h6,
    OP_SUPV_RESTORE = 4'h7,
    OP_MODEL_READ = 4'h8,
    OP_MODEL_WRITE = 4'h9,
    OP_CR4_WRITE = 4'hA,
    OP_WIDE_INSTR = 4'hB,
    OP_LEGACY_INSTR = 4'hC
  } ssfg_op_t;

  typedef struct packed {
    ssfg_op_t op;
    logic [1:0] cur_priv;
    logic [31:0] ecx;
    logic [63:0] operand;
  } ssfg_req_t;

  typedef struct packed {
    logic [31:0] eax;
    logic [31:0] ebx;
    logic [31:0] ecx;
    logic [31:0] edx;
  } ssfg_id_t;

  function automatic logic [31:0] comp_bytes(input int unsigned i);
    comp_bytes = (i == COMP_WIDE) ? WIDE_BYTES : 32'h0000_0000;
  endfunction

  function automatic logic [31:0] comp_offset(input int unsigned i);
    comp_offset = (i == COMP_WIDE) ? WIDE_OFFSET : 32'h0000_0000;
  endfunction

  function automatic logic [31:0] area_bytes(input logic [63:0] map);
    logic [31:0] sum;
    sum = LEGACY_BYTES;
    for (int unsigned i = COMP_WIDE; i < COMP_NUM; i++) begin
      if (map[i]) begin
        sum = sum + comp_bytes(i);
      end
    end
    area_bytes = sum;
  endfunction
endpackage

// *** core/ssfg_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssfg_top (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_OP_VALID,
  input wire ssfg_pkg::ssfg_req_t I_OP_REQ,
  input wire logic I_ID_VALID,
  input wire logic [31:0] I_ID_LEAF,
  input wire logic [31:0] I_ID_SUBLEAF,
  output logic O_OP_DONE,
  output logic O_INVOP_FAULT,
  output logic O_PROT_FAULT,
  output logic [63:0] O_READ_DATA,
  output logic [63:0] O_COMP_MASK,
  output logic [63:0] O_STATE_ENABLE,
  output logic [63:0] O_SUPV_MASK,
  output logic O_OS_ENABLE,
  output logic O_WIDE_WRITABLE,
  output logic O_ID_DONE,
  output ssfg_pkg::ssfg_id_t O_ID_RESULT
);
  logic [63:0] enable_r;
  logic [63:0] enable_nxt;
  logic [63:0] supv_r;
  logic [63:0] supv_nxt;
  logic osen_r;
  logic osen_nxt;
  logic invop_nxt;
  logic prot_nxt;
  logic [63:0] rdata_nxt;
  logic [63:0] cmask_nxt;
  logic [63:0] opnd;
  logic [31:0] sel;
  logic priv;
  logic feat_off;
  logic wide_ok_r;
  logic invop_r;
  logic prot_r;
  logic done_r;
  logic [63:0] rdata_r;
  logic [63:0] cmask_r;
  logic id_done_r;
  ssfg_pkg::ssfg_id_t id_r;
  ssfg_pkg::ssfg_id_t id_nxt;

  assign opnd = I_OP_REQ.operand;
  assign sel = I_OP_REQ.ecx;
  assign priv = (I_OP_REQ.cur_priv == 2'h0);
  assign feat_off = !osen_r || !ssfg_pkg::HAS_BASIC;

  // instruction checks and register updates
  always_comb begin
    invop_nxt = 1'b0;
    prot_nxt = 1'b0;
    rdata_nxt = 64'h0000_0000_0000_0000;
    cmask_nxt = 64'h0000_0000_0000_0000;
    enable_nxt = enable_r;
    supv_nxt = supv_r;
    osen_nxt = osen_r;
    if (I_OP_VALID) begin
      unique case (I_OP_REQ.op)
        ssfg_pkg::OP_ENABLE_READ: begin
          if (feat_off) begin
            invop_nxt = 1'b1;
          end else if (sel == ssfg_pkg::SEL_ENABLE) begin
            rdata_nxt = enable_r;
          end else if (sel == ssfg_pkg::SEL_INIT && ssfg_pkg::HAS_READ1) begin
            rdata_nxt = enable_r;
          end else begin
            prot_nxt = 1'b1;
          end
        end
        ssfg_pkg::OP_ENABLE_WRITE: begin
          if (feat_off) begin
            invop_nxt = 1'b1;
          end else if (!priv) begin
            prot_nxt = 1'b1;
          end else if (sel != ssfg_pkg::SEL_ENABLE) begin
            prot_nxt = 1'b1;
          end else if (!opnd[ssfg_pkg::COMP_LEGACY]) begin
            prot_nxt = 1'b1;
          end else if (opnd[2:1] == 2'h2) begin
            prot_nxt = 1'b1;
          end else if (opnd[63:3] != 61'h0) begin
            prot_nxt = 1'b1;
          end else if ((opnd & ~ssfg_pkg::FULL_MAP) != 64'h0) begin
            prot_nxt = 1'b1;
          end else begin
            enable_nxt = opnd;
          end
        end
        ssfg_pkg::OP_STD_SAVE, ssfg_pkg::OP_STD_RESTORE: begin
          if (feat_off) begin
            invop_nxt = 1'b1;
          end else begin
            cmask_nxt = opnd & enable_r;
          end
        end
        ssfg_pkg::OP_OPT_SAVE: begin
          if (feat_off || !ssfg_pkg::HAS_OPT) begin
            invop_nxt = 1'b1;
          end else begin
            cmask_nxt = opnd & enable_r;
          end
        end
        ssfg_pkg::OP_COMPACT_SAVE: begin
          if (feat_off || !ssfg_pkg::HAS_COMPACT) begin
            invop_nxt = 1'b1;
          end else begin
            cmask_nxt = opnd & enable_r;
          end
        end
        ssfg_pkg::OP_SUPV_SAVE, ssfg_pkg::OP_SUPV_RESTORE: begin
          if (feat_off || !ssfg_pkg::HAS_SUPV) begin
            invop_nxt = 1'b1;
          end else if (!priv) begin
            prot_nxt = 1'b1;
          end else begin
            cmask_nxt = opnd & (enable_r | supv_r);
          end
        end
        ssfg_pkg::OP_MODEL_READ: begin
          if (sel != ssfg_pkg::SUPV_MASK_INDEX || !ssfg_pkg::HAS_SUPV || !priv) begin
            prot_nxt = 1'b1;
          end else begin
            rdata_nxt = supv_r;
          end
        end
        ssfg_pkg::OP_MODEL_WRITE: begin
          if (sel != ssfg_pkg::SUPV_MASK_INDEX || !ssfg_pkg::HAS_SUPV || !priv) begin
            prot_nxt = 1'b1;
          end else if (!osen_r) begin
            prot_nxt = 1'b1;
          end else if ((opnd & ~ssfg_pkg::SUPV_MAP) != 64'h0) begin
            prot_nxt = 1'b1;
          end else begin
            supv_nxt = opnd;
          end
        end
        ssfg_pkg::OP_CR4_WRITE: begin
          if (!priv) begin
            prot_nxt = 1'b1;
          end else if (opnd[ssfg_pkg::CR4_OSEN_BIT] && !ssfg_pkg::HAS_BASIC) begin
            prot_nxt = 1'b1;
          end else begin
            osen_nxt = opnd[ssfg_pkg::CR4_OSEN_BIT];
          end
        end
        ssfg_pkg::OP_WIDE_INSTR: begin
          // all components of the feature must be enabled
          if (!osen_r || !enable_r[ssfg_pkg::COMP_SIMD] ||
              !enable_r[ssfg_pkg::COMP_WIDE]) begin
            invop_nxt = 1'b1;
          end
        end
        ssfg_pkg::OP_LEGACY_INSTR: begin
          invop_nxt = 1'b0;
        end
        default: begin
          invop_nxt = 1'b1;
        end
      endcase
    end
    cmask_nxt[ssfg_pkg::SPECIAL_BIT] = 1'b0;
  end

  // enable mask, bit 0 pinned high
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      enable_r <= ssfg_pkg::ENABLE_RESET;
    end else begin
      enable_r <= enable_nxt | ssfg_pkg::ENABLE_RESET;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      supv_r <= ssfg_pkg::SUPV_RESET;
    end else begin
      supv_r <= supv_nxt;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      osen_r <= ssfg_pkg::OSEN_RESET;
    end else begin
      osen_r <= osen_nxt;
    end
  end

  // wide-vector registers locked unless enabled
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      wide_ok_r <= 1'b0;
    end else begin
      wide_ok_r <= osen_nxt && enable_nxt[ssfg_pkg::COMP_WIDE];
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      done_r <= 1'b0;
      invop_r <= 1'b0;
      prot_r <= 1'b0;
      rdata_r <= 64'h0000_0000_0000_0000;
      cmask_r <= 64'h0000_0000_0000_0000;
    end else begin
      done_r <= I_OP_VALID;
      invop_r <= invop_nxt;
      prot_r <= prot_nxt;
      rdata_r <= rdata_nxt;
      cmask_r <= cmask_nxt;
    end
  end

  // identification query answers
  always_comb begin
    id_nxt = '0;
    if (I_ID_LEAF == ssfg_pkg::LEAF_BASIC) begin
      id_nxt.ecx[ssfg_pkg::L1_CLMUL_BIT] = ssfg_pkg::HAS_CLMUL;
      id_nxt.ecx[ssfg_pkg::L1_ROUND_BIT] = ssfg_pkg::HAS_ROUND;
      id_nxt.ecx[ssfg_pkg::L1_BASIC_BIT] = ssfg_pkg::HAS_BASIC;
      id_nxt.ecx[ssfg_pkg::L1_OSEN_BIT] = osen_r;
    end else if (I_ID_LEAF == ssfg_pkg::LEAF_STATE && ssfg_pkg::HAS_BASIC) begin
      if (I_ID_SUBLEAF == 32'h0000_0000) begin
        id_nxt.eax = ssfg_pkg::FULL_MAP[31:0];
        id_nxt.edx = ssfg_pkg::FULL_MAP[63:32];
        id_nxt.ebx = ssfg_pkg::area_bytes(enable_r);
        id_nxt.ecx = ssfg_pkg::area_bytes(ssfg_pkg::FULL_MAP);
      end else if (I_ID_SUBLEAF == 32'h0000_0001) begin
        id_nxt.eax[ssfg_pkg::S1_OPT_BIT] = ssfg_pkg::HAS_OPT;
        id_nxt.eax[ssfg_pkg::S1_COMPACT_BIT] =
          ssfg_pkg::HAS_COMPACT | ssfg_pkg::HAS_SUPV;
        id_nxt.eax[ssfg_pkg::S1_READ1_BIT] = ssfg_pkg::HAS_READ1;
        id_nxt.eax[ssfg_pkg::S1_SUPV_BIT] = ssfg_pkg::HAS_SUPV;
        id_nxt.ebx = ssfg_pkg::area_bytes(enable_r | supv_r);
        id_nxt.ecx = ssfg_pkg::SUPV_MAP[31:0];
        id_nxt.edx = ssfg_pkg::SUPV_MAP[63:32];
      end else if (I_ID_SUBLEAF < 32'h0000_003F) begin
        if (ssfg_pkg::FULL_MAP[I_ID_SUBLEAF[5:0]]) begin
          id_nxt.eax = ssfg_pkg::comp_bytes(32'(I_ID_SUBLEAF[5:0]));
          id_nxt.ebx = ssfg_pkg::comp_offset(32'(I_ID_SUBLEAF[5:0]));
        end else if (ssfg_pkg::SUPV_MAP[I_ID_SUBLEAF[5:0]]) begin
          id_nxt.eax = ssfg_pkg::comp_bytes(32'(I_ID_SUBLEAF[5:0]));
          id_nxt.ecx = 32'h0000_0001;
        end
        // anything else stays all zero
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      id_done_r <= 1'b0;
      id_r <= '0;
    end else begin
      id_done_r <= I_ID_VALID;
      id_r <= id_nxt;
    end
  end

  assign O_OP_DONE = done_r;
  assign O_INVOP_FAULT = invop_r;
  assign O_PROT_FAULT = prot_r;
  assign O_READ_DATA = rdata_r;
  assign O_COMP_MASK = cmask_r;
  assign O_STATE_ENABLE = enable_r;
  assign O_SUPV_MASK = supv_r;
  assign O_OS_ENABLE = osen_r;
  assign O_WIDE_WRITABLE = wide_ok_r;
  assign O_ID_DONE = id_done_r;
  assign O_ID_RESULT = id_r;
endmodule // ssfg_top
`default_nettype wire

// *** test/ssfg_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssfg_assertions (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_OP_VALID,
  input wire ssfg_pkg::ssfg_req_t I_OP_REQ,
  input wire logic O_OP_DONE,
  input wire logic O_INVOP_FAULT,
  input wire logic O_PROT_FAULT,
  input wire logic [63:0] O_COMP_MASK,
  input wire logic [63:0] O_STATE_ENABLE,
  input wire logic [63:0] O_SUPV_MASK,
  input wire logic O_OS_ENABLE,
  input wire logic O_WIDE_WRITABLE
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  enable_one_a: assert property (O_STATE_ENABLE[0])
    else $error("enable mask bit 0 is clear");
  enable_legal_a: assert property ((O_STATE_ENABLE & ~ssfg_pkg::FULL_MAP) == 64'h0)
    else $error("enable mask holds an unsupported bit");
  wide_gate_a: assert property (O_WIDE_WRITABLE == (O_OS_ENABLE && O_STATE_ENABLE[2]))
    else $error("wide state gating wrong");
  priv_write_a: assert property (I_OP_VALID && O_OS_ENABLE && I_OP_REQ.cur_priv != 2'h0
    && I_OP_REQ.op == ssfg_pkg::OP_ENABLE_WRITE |=> O_OP_DONE && O_PROT_FAULT)
    else $error("unprivileged enable write not refused");
  osen_invop_a: assert property (I_OP_VALID && !O_OS_ENABLE && !I_OP_REQ.op[3] |=> O_INVOP_FAULT)
    else $error("state op ran while feature disabled");
  std_skip_a: assert property (I_OP_VALID && I_OP_REQ.op == ssfg_pkg::OP_STD_SAVE
    |=> (O_COMP_MASK & ~$past(O_STATE_ENABLE)) == 64'h0)
    else $error("save touched a disabled component");
  supv_or_a: assert property (I_OP_VALID && I_OP_REQ.op == ssfg_pkg::OP_SUPV_SAVE
    |=> (O_COMP_MASK & ~($past(O_STATE_ENABLE) | $past(O_SUPV_MASK))) == 64'h0)
    else $error("supervisor save outside both masks");
  fault_keeps_a: assert property (O_OP_DONE && (O_PROT_FAULT || O_INVOP_FAULT)
    |-> $stable(O_STATE_ENABLE) && $stable(O_OS_ENABLE))
    else $error("faulting request changed state");
  legacy_free_a: assert property (I_OP_VALID && I_OP_REQ.op == ssfg_pkg::OP_LEGACY_INSTR
    |=> O_OP_DONE && !O_INVOP_FAULT)
    else $error("legacy instruction refused");
  comp_top_a: assert property (O_COMP_MASK[63] == 1'b0)
    else $error("component mask bit 63 set");
  cover property (I_OP_VALID && I_OP_REQ.op == ssfg_pkg::OP_STD_SAVE ##1 !O_INVOP_FAULT);
  cover property (O_OP_DONE && O_PROT_FAULT);
  cover property (O_OP_DONE && O_INVOP_FAULT);
endmodule // ssfg_assertions
bind ssfg_top ssfg_assertions chk_i (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_OP_VALID(I_OP_VALID),
  .I_OP_REQ(I_OP_REQ), .O_OP_DONE(O_OP_DONE), .O_INVOP_FAULT(O_INVOP_FAULT),
  .O_PROT_FAULT(O_PROT_FAULT), .O_COMP_MASK(O_COMP_MASK), .O_STATE_ENABLE(O_STATE_ENABLE),
  .O_SUPV_MASK(O_SUPV_MASK), .O_OS_ENABLE(O_OS_ENABLE), .O_WIDE_WRITABLE(O_WIDE_WRITABLE));
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {
    logic [3:0] op;
    logic [1:0] pr;
    logic [31:0] ecx;
    logic [63:0] opnd;
    logic invop;
    logic prot;
    logic [63:0] val;
  } ssfg_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  ssfg_pkg::ssfg_req_t req = '0;
  logic id_valid = 1'b0;
  logic [31:0] leaf = 32'h0;
  logic [31:0] sub = 32'h0;
  logic done, invop, prot, wide_wr, os_en, id_done;
  logic [63:0] rdata, cmask, en_mask, sv_mask;
  ssfg_pkg::ssfg_id_t id_res;
  int mismatches = 0;
  int checks_done = 0;
  ssfg_row_t rows [25];

  always #2 clk = ~clk;

  ssfg_top dut (
    .I_CLK(clk),
    .I_NRST(rst_n),
    .I_OP_VALID(op_valid),
    .I_OP_REQ(req),
    .I_ID_VALID(id_valid),
    .I_ID_LEAF(leaf),
    .I_ID_SUBLEAF(sub),
    .O_OP_DONE(done),
    .O_INVOP_FAULT(invop),
    .O_PROT_FAULT(prot),
    .O_READ_DATA(rdata),
    .O_COMP_MASK(cmask),
    .O_STATE_ENABLE(en_mask),
    .O_SUPV_MASK(sv_mask),
    .O_OS_ENABLE(os_en),
    .O_WIDE_WRITABLE(wide_wr),
    .O_ID_DONE(id_done),
    .O_ID_RESULT(id_res)
  );

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic run(input ssfg_row_t r);
    @(posedge clk);
    op_valid <= 1'b1;
    req <= '{ssfg_pkg::ssfg_op_t'(r.op), r.pr, r.ecx, r.opnd};
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask

  task automatic idq(input logic [31:0] l, input logic [31:0] s);
    @(posedge clk);
    id_valid <= 1'b1;
    leaf <= l;
    sub <= s;
    @(posedge clk);
    id_valid <= 1'b0;
    #1;
    chk(id_done, 1'h1);
  endtask

  // run needs about 80 cycles
  initial begin
    #20000;
    mismatches++;
    end_sim();
  end

  initial begin
    rows = '{
      '{4'h0, 2'h0, 32'h0, 64'h0, 1'h1, 1'h0, 64'h0},
      '{4'hC, 2'h3, 32'h0, 64'h0, 1'h0, 1'h0, 64'h0},
      '{4'hB, 2'h0, 32'h0, 64'h0, 1'h1, 1'h0, 64'h0},
      '{4'hA, 2'h0, 32'h0, 64'h4_0000, 1'h0, 1'h0, 64'h0},
      '{4'h1, 2'h3, 32'h0, 64'h7, 1'h0, 1'h1, 64'h0},
      '{4'h1, 2'h0, 32'h0, 64'h6, 1'h0, 1'h1, 64'h0},
      '{4'h1, 2'h0, 32'h0, 64'h5, 1'h0, 1'h1, 64'h0},
      '{4'h1, 2'h0, 32'h0, 64'h1_0000_0003, 1'h0, 1'h1, 64'h0},
      '{4'h1, 2'h0, 32'h0, 64'hB, 1'h0, 1'h1, 64'h0},
      '{4'h1, 2'h0, 32'h2, 64'h3, 1'h0, 1'h1, 64'h0},
      '{4'h1, 2'h0, 32'h0, 64'h3, 1'h0, 1'h0, 64'h0},
      '{4'hB, 2'h0, 32'h0, 64'h0, 1'h1, 1'h0, 64'h0},
      '{4'h2, 2'h3, 32'h0, 64'hFFFF_FFFF_FFFF_FFFF, 1'h0, 1'h0, 64'h3},
      '{4'h1, 2'h0, 32'h0, 64'h7, 1'h0, 1'h0, 64'h0},
      '{4'h0, 2'h3, 32'h0, 64'h0, 1'h0, 1'h0, 64'h7},
      '{4'hB, 2'h3, 32'h0, 64'h0, 1'h0, 1'h0, 64'h0},
      '{4'h5, 2'h3, 32'h0, 64'h7, 1'h0, 1'h1, 64'h0},
      '{4'h5, 2'h0, 32'h0, 64'hFFFF_FFFF_FFFF_FFFF, 1'h0, 1'h0, 64'h7},
      '{4'h3, 2'h3, 32'h0, 64'h5, 1'h0, 1'h0, 64'h5},
      '{4'h4, 2'h3, 32'h0, 64'h6, 1'h0, 1'h0, 64'h6},
      '{4'h9, 2'h0, 32'hDA0, 64'h1, 1'h0, 1'h1, 64'h0},
      '{4'h8, 2'h0, 32'hDA0, 64'h0, 1'h0, 1'h0, 64'h0},
      '{4'h8, 2'h0, 32'h1, 64'h0, 1'h0, 1'h1, 64'h0},
      '{4'h6, 2'h3, 32'h0, 64'hF, 1'h0, 1'h0, 64'h7},
      '{4'h7, 2'h0, 32'h0, 64'h3, 1'h0, 1'h0, 64'h3}
    };
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      run(rows[i]);
      chk({done, invop, prot}, {1'h1, rows[i].invop, rows[i].prot});
      if (!rows[i].invop && !rows[i].prot && rows[i].op inside {4'h0, 4'h8}) begin
        chk(rdata, rows[i].val);
      end
      if (!rows[i].invop && !rows[i].prot && rows[i].op inside {[4'h2:4'h7]}) begin
        chk(cmask, rows[i].val);
      end
    end
    chk(wide_wr, 1'h1);
    idq(32'h1, 32'h0);
    chk(id_res.ecx & 32'h0E00_0002, 32'h0E00_0002);
    idq(32'hD, 32'h0);
    chk(id_res, {32'h7, 32'h340, 32'h340, 32'h0});
    idq(32'hD, 32'h1);
    chk(id_res, {32'hF, 32'h340, 32'h0, 32'h0});
    idq(32'hD, 32'h2);
    chk(id_res, {32'h100, 32'h240, 32'h0, 32'h0});
    idq(32'hD, 32'h3);
    chk(id_res, 128'h0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({en_mask, os_en, wide_wr}, {64'h1, 2'h0});
    chk(sv_mask, 64'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    idq(32'hD, 32'h0);
    chk(id_res, {32'h7, 32'h240, 32'h340, 32'h0});
    end_sim();
  end
endmodule // testbench
`default_nettype wire
